// file: bssc_top.sv
`timescale 1ns/10ps
`default_nettype none

module bssc_top
    import bssc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic is_main_i,
    input wire logic bit_tick_i,
    input wire logic loc_wr_i,
    input wire logic [7:0] loc_addr_i,
    input wire logic [7:0] loc_wdata_i,
    input wire logic bus_wr_i,
    input wire logic [7:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic [7:0] rd_addr_i,
    input wire logic new_structure_i,
    output logic [7:0] rd_data_o,
    output logic bcast_wr_o,
    output logic [7:0] bcast_addr_o,
    output logic [7:0] bcast_data_o,
    output logic superframe_start_o,
    output logic up_header_start_o,
    output logic structure_pending_o,
    output logic down_mask_enable_o,
    output logic [5:0] down_capture_count_o,
    output logic [5:0] down_add_count_o,
    output logic [5:0] up_add_count_o,
    output logic [5:0] down_pass_count_o,
    output logic [5:0] up_pass_count_o,
    output logic [7:0] response_cycles_o,
    output logic [5:0] up_slot_bits_o,
    output logic [5:0] up_serial_bits_o,
    output logic up_compress_o,
    output logic up_ecc_o,
    output logic [2:0] up_ecc_bits_o,
    output logic up_parity_o,
    output logic up_size_reserved_o,
    output logic [5:0] down_slot_bits_o,
    output logic [5:0] down_serial_bits_o,
    output logic down_compress_o,
    output logic down_ecc_o,
    output logic [2:0] down_ecc_bits_o,
    output logic down_parity_o,
    output logic down_size_reserved_o
);

    // ------------------------------------------------------------
    // address decode, shared by both write ports and the read port
    // ------------------------------------------------------------
    function automatic logic [6:0] bssc_sel(input logic [7:0] addr);
        bssc_sel = {addr == BSSC_STAT_OFS, addr == BSSC_FMT_OFS,
                    addr == BSSC_RESP_OFS, addr == BSSC_UP_OFS,
                    addr == BSSC_DN_OFS, addr == BSSC_LUP_OFS,
                    addr == BSSC_LDN_OFS};
    endfunction : bssc_sel

    localparam int SEL_LDN = 0;
    localparam int SEL_LUP = 1;
    localparam int SEL_DN = 2;
    localparam int SEL_UP = 3;
    localparam int SEL_RESP = 4;
    localparam int SEL_FMT = 5;
    localparam int SEL_STAT = 6;

    wire logic [6:0] loc_sel = bssc_sel(loc_addr_i);
    wire logic [6:0] bus_sel = bssc_sel(bus_addr_i);
    wire logic [6:0] rd_sel = bssc_sel(rd_addr_i);

    // ------------------------------------------------------------
    // write acceptance
    // ------------------------------------------------------------
    // a bus write in the same cycle as a local one wins, since it
    // carries the main node's view of the structure
    wire logic loc_ok = loc_wr_i && !bus_wr_i;
    wire logic [6:0] loc_en = loc_ok ? loc_sel : 7'h00;
    wire logic [6:0] bus_en = bus_wr_i ? bus_sel : 7'h00;
    wire logic loc_resp_ok = 1'b0;
    wire logic loc_fmt_ok = is_main_i;
    wire logic [6:0] wr_en = bus_en | {loc_en[6], loc_en[SEL_FMT] &&
        loc_fmt_ok, loc_en[SEL_RESP] && loc_resp_ok, loc_en[3:0]};
    wire logic [7:0] wdata = bus_wr_i ? bus_wdata_i : loc_wdata_i;
    wire logic fmt_bcast = loc_en[SEL_FMT] && is_main_i;

    // ------------------------------------------------------------
    // written (shadow) registers
    // ------------------------------------------------------------
    logic [7:0] local_downstream_slot_count;
    logic [7:0] local_upstream_slot_count;
    logic [7:0] downstream_slot_count;
    logic [7:0] upstream_slot_count;
    logic [7:0] response_cycle_count;
    logic [7:0] slot_size_format;

    // slot counts keep only their six bits, local downstream also its bit 7; other upper bits read as zero
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            local_downstream_slot_count <= BSSC_LDN_RST;
            local_upstream_slot_count <= BSSC_LUP_RST;
            downstream_slot_count <= BSSC_DN_RST;
            upstream_slot_count <= BSSC_UP_RST;
            response_cycle_count <= BSSC_RESP_RST;
            slot_size_format <= BSSC_FMT_RST;
        end else begin
            if (wr_en[SEL_LDN])
                local_downstream_slot_count <= wdata & BSSC_LDN_MASK;
            if (wr_en[SEL_LUP])
                local_upstream_slot_count <= wdata & BSSC_COUNT_MASK;
            if (wr_en[SEL_DN])
                downstream_slot_count <= wdata & BSSC_COUNT_MASK;
            if (wr_en[SEL_UP])
                upstream_slot_count <= wdata & BSSC_COUNT_MASK;
            if (wr_en[SEL_RESP])
                response_cycle_count <= wdata;
            if (wr_en[SEL_FMT])
                slot_size_format <= wdata & BSSC_FMT_MASK;
        end
    end

    // ------------------------------------------------------------
    // auto-broadcast of slot-format writes made in the main node
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bcast_wr_o <= 1'b0;
            bcast_addr_o <= 8'h00;
            bcast_data_o <= 8'h00;
        end else begin
            bcast_wr_o <= fmt_bcast;
            if (fmt_bcast) begin
                bcast_addr_o <= BSSC_FMT_OFS;
                bcast_data_o <= wdata & BSSC_FMT_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // superframe timing
    // ------------------------------------------------------------
    logic [9:0] bit_pos;
    wire logic [10:0] up_hdr_pos = 11'(response_cycles_o) *
        BSSC_RESP_MULT + BSSC_RESP_OFFSET;
    wire logic frame_begin = bit_tick_i && (bit_pos == 10'h000);

    // ten bits wrap naturally after the last bit of the frame
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bit_pos <= 10'h000;
            superframe_start_o <= 1'b0;
            up_header_start_o <= 1'b0;
        end else begin
            if (bit_tick_i)
                bit_pos <= bit_pos + 10'h001;
            superframe_start_o <= frame_begin;
            up_header_start_o <= bit_tick_i &&
                ({1'b0, bit_pos} == up_hdr_pos);
        end
    end

    // ------------------------------------------------------------
    // new-structure sequencing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BSSC_IDLE = 3'b001,
        BSSC_WAIT = 3'b010,
        BSSC_LOAD = 3'b100
    } bssc_state_t;

    bssc_state_t state;
    bssc_state_t next_state;

    // the switch waits for a frame boundary so no frame mixes old and
    // new layouts; that costs at most one superframe, well inside five
    always_comb begin
        next_state = state;
        case (state)
            BSSC_IDLE: begin
                if (new_structure_i)
                    next_state = BSSC_WAIT;
            end
            BSSC_WAIT: begin
                if (frame_begin)
                    next_state = BSSC_LOAD;
            end
            BSSC_LOAD: begin
                next_state = new_structure_i ? BSSC_WAIT : BSSC_IDLE;
            end
            default: begin
                next_state = BSSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            state <= BSSC_IDLE;
        else
            state <= next_state;
    end

    wire logic apply = (state == BSSC_LOAD);
    assign structure_pending_o = (state == BSSC_WAIT);

    // ------------------------------------------------------------
    // active slot plan, taken from the shadows only on apply
    // ------------------------------------------------------------
    wire logic ldn_mask = local_downstream_slot_count[BSSC_MASK_EN_BIT];
    wire logic [5:0] ldn_cnt = local_downstream_slot_count[5:0];

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            down_mask_enable_o <= 1'b0;
            down_capture_count_o <= 6'h00;
            down_add_count_o <= 6'h00;
            up_add_count_o <= 6'h00;
            down_pass_count_o <= 6'h00;
            up_pass_count_o <= 6'h00;
            response_cycles_o <= BSSC_RESP_RST;
        end else if (apply) begin
            down_mask_enable_o <= ldn_mask;
            down_capture_count_o <= ldn_mask ? 6'h00 : ldn_cnt;
            down_add_count_o <= ldn_mask ? ldn_cnt : 6'h00;
            up_add_count_o <= is_main_i ? 6'h00
                : local_upstream_slot_count[5:0];
            // main: total sent; subordinate: passed on after capture
            down_pass_count_o <= downstream_slot_count[5:0];
            // main: expected from first node; subordinate: forwarded
            up_pass_count_o <= upstream_slot_count[5:0];
            response_cycles_o <= response_cycle_count;
        end
    end

    // ------------------------------------------------------------
    // per-direction format decode; index 0 upstream, 1 downstream
    // ------------------------------------------------------------
    wire logic [1:0] dir_fmt = {slot_size_format[BSSC_DN_FMT_BIT],
                                slot_size_format[BSSC_UP_FMT_BIT]};
    wire logic [2:0] dir_size [2];
    logic [5:0] dir_slot_bits [2];
    logic [5:0] dir_serial_bits [2];
    logic [1:0] dir_comp;
    logic [1:0] dir_ecc;
    logic [2:0] dir_ecc_bits [2];
    logic [1:0] dir_parity;
    logic [1:0] dir_rsv;

    assign dir_size[0] = slot_size_format[BSSC_UP_SIZE_LSB +: 3];
    assign dir_size[1] = slot_size_format[BSSC_DN_SIZE_LSB +: 3];

    genvar d;
    generate
        for (d = 0; d < 2; d = d + 1) begin : g_dir
            bssc_fmt_decode u_dec (
                .core_clk_i(core_clk_i),
                .nrst_i(nrst_i),
                .load_i(apply),
                .fmt_sel_i(dir_fmt[d]),
                .size_code_i(dir_size[d]),
                .slot_bits_o(dir_slot_bits[d]),
                .serial_bits_o(dir_serial_bits[d]),
                .compress_o(dir_comp[d]),
                .ecc_o(dir_ecc[d]),
                .ecc_bits_o(dir_ecc_bits[d]),
                .parity_o(dir_parity[d]),
                .size_reserved_o(dir_rsv[d])
            );
        end
    endgenerate

    assign up_slot_bits_o = dir_slot_bits[0];
    assign up_serial_bits_o = dir_serial_bits[0];
    assign up_compress_o = dir_comp[0];
    assign up_ecc_o = dir_ecc[0];
    assign up_ecc_bits_o = dir_ecc_bits[0];
    assign up_parity_o = dir_parity[0];
    assign up_size_reserved_o = dir_rsv[0];
    assign down_slot_bits_o = dir_slot_bits[1];
    assign down_serial_bits_o = dir_serial_bits[1];
    assign down_compress_o = dir_comp[1];
    assign down_ecc_o = dir_ecc[1];
    assign down_ecc_bits_o = dir_ecc_bits[1];
    assign down_parity_o = dir_parity[1];
    assign down_size_reserved_o = dir_rsv[1];

    // ------------------------------------------------------------
    // register readback; status shows the pending flag and node role
    // ------------------------------------------------------------
    wire logic [7:0] stat_word = {6'h00, is_main_i, structure_pending_o};
    wire logic [7:0] next_rd =
        rd_sel[SEL_LDN] ? local_downstream_slot_count :
        rd_sel[SEL_LUP] ? local_upstream_slot_count :
        rd_sel[SEL_DN] ? downstream_slot_count :
        rd_sel[SEL_UP] ? upstream_slot_count :
        rd_sel[SEL_RESP] ? response_cycle_count :
        rd_sel[SEL_FMT] ? slot_size_format :
        rd_sel[SEL_STAT] ? stat_word : 8'h00;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            rd_data_o <= 8'h00;
        else
            rd_data_o <= next_rd;
    end

endmodule : bssc_top

`default_nettype wire

// file: bssc_pkg.sv
package bssc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] BSSC_LDN_OFS = 8'h0b;
    localparam logic [7:0] BSSC_LUP_OFS = 8'h0c;
    localparam logic [7:0] BSSC_DN_OFS = 8'h0d;
    localparam logic [7:0] BSSC_UP_OFS = 8'h0e;
    localparam logic [7:0] BSSC_RESP_OFS = 8'h0f;
    localparam logic [7:0] BSSC_FMT_OFS = 8'h10;
    localparam logic [7:0] BSSC_STAT_OFS = 8'h11;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] BSSC_LDN_RST = 8'h00;
    localparam logic [7:0] BSSC_LUP_RST = 8'h00;
    localparam logic [7:0] BSSC_DN_RST = 8'h00;
    localparam logic [7:0] BSSC_UP_RST = 8'h00;
    localparam logic [7:0] BSSC_RESP_RST = 8'h00;
    localparam logic [7:0] BSSC_FMT_RST = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BSSC_MASK_EN_BIT = 7;
    localparam logic [7:0] BSSC_COUNT_MASK = 8'h3f;
    localparam logic [7:0] BSSC_LDN_MASK = 8'hbf;
    localparam int BSSC_UP_FMT_BIT = 7;
    localparam int BSSC_UP_SIZE_LSB = 4;
    localparam int BSSC_DN_FMT_BIT = 3;
    localparam int BSSC_DN_SIZE_LSB = 0;
    localparam logic [7:0] BSSC_FMT_MASK = 8'hff;

    // ------------------------------------------------------------
    // timing and format figures
    // ------------------------------------------------------------
    localparam int BSSC_SUPERFRAME_BITS = 1024;
    localparam logic [10:0] BSSC_RESP_MULT = 11'h004;
    localparam logic [10:0] BSSC_RESP_OFFSET = 11'h007;
    localparam int BSSC_APPLY_MAX_FRAMES = 5;
    localparam logic [5:0] BSSC_SIZE_BASE = 6'h08;
    localparam logic [5:0] BSSC_SIZE_STEP = 6'h04;
    localparam logic [5:0] BSSC_COMP_WIDEN = 6'h04;
    localparam logic [2:0] BSSC_ECC24_BITS = 3'h6;
    localparam logic [2:0] BSSC_ECC32_BITS = 3'h7;
    localparam logic [2:0] BSSC_SIZE_RESERVED = 3'h7;

    // slot size codes, 8 to 32 bits in steps of four, and the reserved code
    typedef enum logic [2:0] {
        BSSC_SZ8 = 3'h0,
        BSSC_SZ12 = 3'h1,
        BSSC_SZ16 = 3'h2,
        BSSC_SZ20 = 3'h3,
        BSSC_SZ24 = 3'h4,
        BSSC_SZ28 = 3'h5,
        BSSC_SZ32 = 3'h6,
        BSSC_SZRSV = 3'h7
    } bssc_size_t;

endpackage : bssc_pkg

// file: bssc_fmt_decode.sv
`timescale 1ns/10ps
`default_nettype none

module bssc_fmt_decode
    import bssc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic load_i,
    input wire logic fmt_sel_i,
    input wire logic [2:0] size_code_i,
    output logic [5:0] slot_bits_o,
    output logic [5:0] serial_bits_o,
    output logic compress_o,
    output logic ecc_o,
    output logic [2:0] ecc_bits_o,
    output logic parity_o,
    output logic size_reserved_o
);

    // ------------------------------------------------------------
    // size and alternate-format decode
    // ------------------------------------------------------------
    wire logic rsv = (size_code_i == BSSC_SZRSV);
    wire logic [5:0] bits = BSSC_SIZE_BASE +
        6'(size_code_i) * BSSC_SIZE_STEP;
    wire logic comp_size = (size_code_i == BSSC_SZ12) ||
        (size_code_i == BSSC_SZ16) || (size_code_i == BSSC_SZ20);
    wire logic ecc_size = (size_code_i == BSSC_SZ24) ||
        (size_code_i == BSSC_SZ32);
    // 8 and 28 bit sizes fall through both tests, so the bit is moot
    wire logic next_comp = fmt_sel_i && comp_size;
    wire logic next_ecc = fmt_sel_i && ecc_size;
    wire logic [2:0] next_ecc_bits = !next_ecc ? 3'h0 :
        (size_code_i == BSSC_SZ24) ? BSSC_ECC24_BITS : BSSC_ECC32_BITS;
    wire logic [5:0] next_serial = next_comp ? bits + BSSC_COMP_WIDEN
                                             : bits;

    // ------------------------------------------------------------
    // decoded format, held until the next structure is applied
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            slot_bits_o <= BSSC_SIZE_BASE;
            serial_bits_o <= BSSC_SIZE_BASE;
            compress_o <= 1'b0;
            ecc_o <= 1'b0;
            ecc_bits_o <= 3'h0;
            parity_o <= 1'b1;
            size_reserved_o <= 1'b0;
        end else if (load_i) begin
            slot_bits_o <= rsv ? 6'h00 : bits;
            serial_bits_o <= rsv ? 6'h00 : next_serial;
            compress_o <= next_comp;
            ecc_o <= next_ecc;
            ecc_bits_o <= next_ecc_bits;
            parity_o <= !next_ecc;
            size_reserved_o <= rsv;
        end
    end

endmodule : bssc_fmt_decode

`default_nettype wire

// file: bssc_node_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// far-side node: free-running bit clock and bus writes
// ----
module bssc_node_model (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic req_wr_i,
    input wire logic [7:0] req_addr_i,
    input wire logic [7:0] req_data_i,
    input wire logic req_new_i,
    output logic bit_tick_o,
    output logic bus_wr_o,
    output logic [7:0] bus_addr_o,
    output logic [7:0] bus_wdata_o,
    output logic new_structure_o
);
    // idle address and data lines toggle so a stale value never passes for data
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bit_tick_o <= 1'b0;
            bus_wr_o <= 1'b0;
            bus_addr_o <= 8'h00;
            bus_wdata_o <= 8'h00;
            new_structure_o <= 1'b0;
        end else begin
            bit_tick_o <= ~bit_tick_o;
            bus_wr_o <= req_wr_i;
            bus_addr_o <= req_wr_i ? req_addr_i : ~bus_addr_o;
            bus_wdata_o <= req_wr_i ? req_data_i : ~bus_wdata_o;
            new_structure_o <= req_new_i;
        end
    end
endmodule : bssc_node_model
`default_nettype wire

// file: bssc_sva.sv
`timescale 1ns/10ps
`default_nettype none
module bssc_sva
    import bssc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic is_main_i,
    input wire logic bit_tick_i,
    input wire logic loc_wr_i,
    input wire logic [7:0] loc_addr_i,
    input wire logic [7:0] loc_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bcast_wr_o,
    input wire logic [7:0] bcast_data_o,
    input wire logic superframe_start_o,
    input wire logic up_header_start_o,
    input wire logic structure_pending_o,
    input wire logic [5:0] up_add_count_o,
    input wire logic [7:0] response_cycles_o,
    input wire logic [5:0] up_slot_bits_o,
    input wire logic [5:0] up_serial_bits_o,
    input wire logic up_compress_o,
    input wire logic up_ecc_o,
    input wire logic [2:0] up_ecc_bits_o,
    input wire logic up_parity_o
);
    // ----
    // bit ticks since the last frame start
    // ----
    logic [10:0] ticks;
    logic armed;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ticks <= 11'h000;
            armed <= 1'b0;
        end else if (superframe_start_o) begin
            ticks <= {10'h000, bit_tick_i};
            armed <= 1'b1;
        end else if (bit_tick_i) begin
            ticks <= ticks + 11'h001;
        end
    end
    // ----
    // bit ticks spent waiting for a new structure; five frames at most
    // ----
    logic [12:0] wait_ticks;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            wait_ticks <= 13'h000;
        else if (!structure_pending_o)
            wait_ticks <= 13'h000;
        else if (bit_tick_i)
            wait_ticks <= wait_ticks + 13'h001;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    bcast_main_a: assert property (is_main_i && loc_wr_i && !bus_wr_i &&
        loc_addr_i == BSSC_FMT_OFS |=> bcast_wr_o &&
        bcast_data_o == $past(loc_wdata_i)) else $error("format not sent");
    bcast_sub_a: assert property (!is_main_i |=> !bcast_wr_o)
        else $error("subordinate broadcast");
    frame_len_a: assert property (superframe_start_o && armed |->
        ticks == 11'h400) else $error("frame length wrong");
    up_hdr_a: assert property (up_header_start_o |-> armed &&
        ticks == ({3'h0, response_cycles_o} << 2) + 11'h007)
        else $error("upstream header misplaced");
    apply_gate_a: assert property ($changed(response_cycles_o) |->
        $past(structure_pending_o, 2)) else $error("early apply");
    apply_time_a: assert property (wait_ticks <= 13'h1400)
        else $error("apply late");
    main_noadd_a: assert property (is_main_i |->
        up_add_count_o == 6'h00) else $error("main adds slots");
    up_ecc_a: assert property (up_ecc_o |-> !up_parity_o &&
        up_ecc_bits_o == (up_slot_bits_o == 6'h18 ? 3'h6 : 3'h7))
        else $error("ecc width wrong");
    up_comp_a: assert property (up_compress_o |-> up_parity_o &&
        up_serial_bits_o == up_slot_bits_o + 6'h04)
        else $error("compression width wrong");
    cover property (bcast_wr_o);
    cover property ($fell(structure_pending_o));
    cover property (up_ecc_o && up_header_start_o);
endmodule : bssc_sva
bind bssc_top bssc_sva i_sva (.*);
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import bssc_pkg::*;;
    logic core_clk_i, nrst_i, is_main_i, loc_wr_i, bit_tick_i, bus_wr_i;
    logic new_structure_i, bcast_wr_o, superframe_start_o;
    logic up_header_start_o, structure_pending_o, down_mask_enable_o;
    logic up_compress_o, up_ecc_o, up_parity_o, up_size_reserved_o;
    logic down_compress_o, down_ecc_o, down_parity_o, down_size_reserved_o;
    logic [7:0] loc_addr_i, loc_wdata_i, bus_addr_i, bus_wdata_i, rd_addr_i;
    logic [7:0] rd_data_o, bcast_addr_o, bcast_data_o, response_cycles_o;
    logic [5:0] down_capture_count_o, down_add_count_o, up_add_count_o;
    logic [5:0] down_pass_count_o, up_pass_count_o, up_slot_bits_o;
    logic [5:0] up_serial_bits_o, down_slot_bits_o, down_serial_bits_o;
    logic [2:0] up_ecc_bits_o, down_ecc_bits_o;
    logic rq_wr, rq_new, c, e;
    logic [7:0] rq_addr, rq_data;
    logic [5:0] b;
    logic [18:0] m, x;
    int err_total, comparisons, n;
    wire logic [18:0] up_f = {up_slot_bits_o, up_serial_bits_o, up_compress_o,
        up_ecc_o, up_ecc_bits_o, up_size_reserved_o, up_parity_o};
    wire logic [18:0] dn_f = {down_slot_bits_o, down_serial_bits_o,
        down_compress_o, down_ecc_o, down_ecc_bits_o, down_size_reserved_o,
        down_parity_o};
    bssc_top i_dut (.*);
    bssc_node_model i_node (.core_clk_i, .nrst_i, .req_wr_i(rq_wr),
        .req_addr_i(rq_addr), .req_data_i(rq_data), .req_new_i(rq_new),
        .bit_tick_o(bit_tick_i), .bus_wr_o(bus_wr_i), .bus_addr_o(bus_addr_i),
        .bus_wdata_o(bus_wdata_i), .new_structure_o(new_structure_i));
    // ----
    // checking and access tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // writes land one edge later over the bus, through the far node
    task automatic wr(input logic bus, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge core_clk_i);
        rq_wr <= bus;
        loc_wr_i <= !bus;
        rq_addr <= a;
        rq_data <= d;
        loc_addr_i <= a;
        loc_wdata_i <= d;
        @(posedge core_clk_i);
        rq_wr <= 1'b0;
        loc_wr_i <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        rd_addr_i <= a;
        repeat (2) @(posedge core_clk_i);
        #1 chk(32'(rd_data_o), 32'(d));
    endtask : rdchk
    // pending can last a whole frame, so the wait is bounded by one
    task automatic apply();
        @(posedge core_clk_i);
        rq_new <= 1'b1;
        @(posedge core_clk_i);
        rq_new <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
        // pending is read settled, a time step after each edge
        for (n = 0; n < 2200 && structure_pending_o !== 1'b0; n++) begin
            @(posedge core_clk_i);
            #1;
        end
        chk(32'(structure_pending_o), 32'h0);
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask : apply
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (60000) @(posedge core_clk_i);
        err_total++;
        results();
    end
    initial begin
        {nrst_i, is_main_i, loc_wr_i, rq_wr, rq_new} = 5'h00;
        {loc_addr_i, loc_wdata_i, rd_addr_i, rq_addr, rq_data} = 40'h0;
        err_total = 0;
        comparisons = 0;
        repeat (10) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        for (int i = 11; i < 17; i++) rdchk(8'(i), 8'h00);
        // subordinate set-up: counts kept within 0..32
        wr(1'b0, 8'h0b, 8'h94);
        wr(1'b0, 8'h0c, 8'hc9);
        wr(1'b0, 8'h0d, 8'h20);
        wr(1'b0, 8'h0e, 8'h1f);
        wr(1'b0, 8'h0f, 8'h33);
        wr(1'b0, 8'h10, 8'hcb);
        wr(1'b0, 8'h12, 8'h77);
        wr(1'b1, 8'h0f, 8'h05);
        rdchk(8'h0c, 8'h09);
        rdchk(8'h0f, 8'h05);
        rdchk(8'h10, 8'h00);
        rdchk(8'h12, 8'h00);
        chk(32'(response_cycles_o), 32'h0);
        apply();
        chk(32'({down_mask_enable_o, down_add_count_o, down_capture_count_o,
            up_add_count_o}), 32'({1'b1, 6'h14, 6'h00, 6'h09}));
        chk(32'({down_pass_count_o, up_pass_count_o, response_cycles_o}),
            32'({6'h20, 6'h1f, 8'h05}));
        wr(1'b0, 8'h0b, 8'h10);
        // every size code in both formats, same code up and down
        for (int f = 0; f < 2; f++) begin
            for (int s = 0; s < 8; s++) begin
                wr(1'b1, 8'h10, {f[0], s[2:0], f[0], s[2:0]});
                apply();
                b = (s == 7) ? 6'h00 : 6'h08 + 6'(s) * 6'h04;
                c = f[0] && s > 0 && s < 4;
                e = f[0] && (s == 4 || s == 6);
                x = {b, c ? b + 6'h04 : b, c, e, e ? (s == 4 ? 3'h6 : 3'h7)
                    : 3'h0, s == 7, !e};
                m = (s == 7) ? 19'h7fffe : 19'h7ffff;
                chk(32'(up_f & m), 32'(x & m));
                chk(32'(dn_f & m), 32'(x & m));
            end
        end
        chk(32'({down_capture_count_o, down_add_count_o}), 32'h400);
        // main node: the role is strapped, so it changes only in reset
        nrst_i <= 1'b0;
        is_main_i <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        wr(1'b0, 8'h0d, 8'h20);
        wr(1'b0, 8'h0e, 8'h1f);
        wr(1'b0, 8'h10, 8'h5a);
        #1 chk(32'({bcast_wr_o, bcast_addr_o, bcast_data_o}), 32'h1105a);
        apply();
        chk(32'({up_add_count_o, down_pass_count_o}), 32'h020);
        chk(32'(up_pass_count_o), 32'h1f);
        rdchk(8'h11, 8'h02);
        rdchk(8'h10, 8'h5a);
        results();
    end
endmodule : testbench
`default_nettype wire
